//--- hdl/mms_pkg.sv
// constants and types for the monitor measurement sequencer
package mms_pkg;
    // ==========================================
    // control field positions
    localparam int FIELD_BIT_ZERO = 0;
    localparam int FIELD_BIT_ONE  = 1;
    localparam int FIELD_BIT_TWO  = 2;
    localparam int FIELD_BIT_FOUR = 4;
    localparam int FIELD_BIT_FIVE = 5;
    // third-control configuration fields handed to their consumers
    localparam int FIELD_INT_ENABLE   = 1;
    localparam int FIELD_INT_POLARITY = 2;
    localparam int FIELD_TIMEOUT_EN   = 6;
    localparam int FIELD_SOFT_RESET   = 7;
    // ==========================================
    // channel codes
    localparam logic [3:0] CH_SUPPLY   = 4'h0;
    localparam logic [3:0] CH_INT_TEMP = 4'h1;
    localparam logic [3:0] CH_EXT_TEMP = 4'h2;
    localparam logic [3:0] CH_AIN_ONE  = 4'h3;
    localparam logic [3:0] CH_AIN_TWO  = 4'h4;
    localparam logic [3:0] CH_AIN_EIGHT = 4'hA;
    localparam int NUM_CH = 11;
    // ==========================================
    // averaging and timing
    localparam logic [4:0] AVG_COUNT   = 5'h10;
    localparam int CAL_TIME_US = 5000;
    localparam int CLK_MHZ     = 50;
    localparam int CAL_CYCLES  = CAL_TIME_US * CLK_MHZ;
    localparam int SLOW_TICKS  = 8192;
    localparam int FAST_TICKS  = 16;
    localparam logic [7:0] FAST_DIV_RESET = 8'h00;
    // ==========================================
    // sequencer states
    typedef enum logic [3:0] {
        ST_CAL  = 4'b0001,
        ST_IDLE = 4'b0010,
        ST_CONV = 4'b0100,
        ST_HOLD = 4'b1000
    } mms_state_e;
endpackage

//--- hdl/mms_conv_timer.sv
// conversion timer: counts converter clock ticks for one conversion
`timescale 1ns/10ps
module mms_conv_timer #(
    parameter int SLOW_TICKS = mms_pkg::SLOW_TICKS,
    parameter int FAST_TICKS = mms_pkg::FAST_TICKS
) (
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    input  wire logic start_i,
    input  wire logic abort_i,
    input  wire logic fast_i,
    output logic      done_o
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        busy;
    logic        next_busy;
    logic        done;
    logic        next_done;

    // ==========================================
    // count down one conversion, abort clears
    always_comb begin
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (abort_i) begin
            next_busy = 1'b0;
            next_cnt  = 16'h0000;
        end else if (start_i) begin
            next_busy = 1'b1;
            next_cnt  = fast_i ? 16'(FAST_TICKS - 1) : 16'(SLOW_TICKS - 1);
        end else if (busy) begin
            if (cnt == 16'h0000) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end
    end

    // timer registers
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cnt  <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign done_o = done;
endmodule // mms_conv_timer

//--- hdl/mms_sequencer.sv
// monitor measurement sequencer top
`timescale 1ns/10ps
module mms_sequencer #(
    parameter int CAL_CYCLES = mms_pkg::CAL_CYCLES,
    parameter int SLOW_TICKS = mms_pkg::SLOW_TICKS,
    parameter int FAST_TICKS = mms_pkg::FAST_TICKS
) (
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] ctrl_one_i,      // first control register
    input  wire logic [7:0] ctrl_two_i,      // second control register
    input  wire logic [7:0] ctrl_three_i,    // third control register
    input  wire logic       spi_select_i,    // pulse: protocol selection seen
    input  wire logic       serial_busy_i,   // level: transaction in progress
    input  wire logic [9:0] adc_code_i,      // raw converter code
    output logic            cal_done_o,
    output logic            monitoring_o,
    output logic [3:0]      channel_o,       // multiplexer select
    output logic            conv_start_o,    // pulse: start one conversion
    output logic            adc_reset_o,     // converter reset on abort
    output logic            fast_clk_o,
    output logic            diode_filter_on_o,
    output logic            ref_supply_o,
    output logic            diode_mode_o,
    output logic            spi_locked_o,
    output logic            result_valid_o,  // pulse: result written
    output logic [3:0]      result_ch_o,
    output logic [9:0]      result_o,
    output logic            int_enable_o,
    output logic            int_active_high_o,
    output logic            timeout_enable_o,
    output logic            soft_reset_o
);
    mms_pkg::mms_state_e state, next_state;
    logic [22:0] cal_cnt, next_cal_cnt;
    logic [3:0]  ch, next_ch;
    logic [4:0]  avg_cnt, next_avg_cnt;
    logic [13:0] acc, next_acc;
    logic        start, next_start;
    logic        spi_lock, next_spi_lock;
    logic        rvalid, next_rvalid;
    logic [9:0]  res, next_res;
    logic [3:0]  rch, next_rch;
    logic        conv_done;
    logic        enable, single, no_avg, diode, fast;

    // control decode
    assign enable = ctrl_one_i[mms_pkg::FIELD_BIT_ZERO];
    assign diode  = ctrl_one_i[mms_pkg::FIELD_BIT_ONE] | ctrl_one_i[mms_pkg::FIELD_BIT_TWO];
    assign single = ctrl_two_i[mms_pkg::FIELD_BIT_FOUR];
    assign no_avg = ctrl_two_i[mms_pkg::FIELD_BIT_FIVE];
    assign fast   = ctrl_three_i[mms_pkg::FIELD_BIT_ZERO];

    mms_conv_timer #(
        .SLOW_TICKS(SLOW_TICKS),
        .FAST_TICKS(FAST_TICKS)
    ) u_timer (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .start_i(start),
        .abort_i(serial_busy_i),
        .fast_i (fast),
        .done_o (conv_done)
    );

    // ==========================================
    // next channel in round-robin order
    function automatic logic [3:0] step_ch(input logic [3:0] c, input logic d);
        logic [3:0] n;
        n = c + 4'h1;
        if (c == mms_pkg::CH_AIN_EIGHT) begin
            n = mms_pkg::CH_SUPPLY;
        end else if (c == mms_pkg::CH_INT_TEMP) begin
            n = d ? mms_pkg::CH_EXT_TEMP : mms_pkg::CH_AIN_ONE;
        end else if (c == mms_pkg::CH_EXT_TEMP) begin
            n = mms_pkg::CH_AIN_TWO + 4'h1;
        end
        return n;
    endfunction

    // ==========================================
    // sequencer state machine
    always_comb begin
        next_state   = state;
        next_cal_cnt = cal_cnt;
        next_ch      = ch;
        next_avg_cnt = avg_cnt;
        next_acc     = acc;
        next_start   = 1'b0;
        next_rvalid  = 1'b0;
        next_res     = res;
        next_rch     = rch;
        unique case (state)
            mms_pkg::ST_CAL: begin
                next_cal_cnt = cal_cnt + 23'h00_0001;
                if (cal_cnt == 23'(CAL_CYCLES - 1)) begin
                    next_state = mms_pkg::ST_IDLE;
                end
            end
            mms_pkg::ST_IDLE: begin
                if (enable && !serial_busy_i) begin
                    next_state   = mms_pkg::ST_CONV;
                    next_ch      = single ? ctrl_two_i[3:0] : mms_pkg::CH_SUPPLY;
                    next_avg_cnt = 5'h00;
                    next_acc     = 14'h0000;
                    next_start   = 1'b1;
                end
            end
            mms_pkg::ST_CONV: begin
                if (!enable) begin
                    next_state = mms_pkg::ST_IDLE;
                end else if (serial_busy_i) begin
                    next_state = mms_pkg::ST_HOLD;
                end else if (conv_done) begin
                    next_acc     = acc + 14'(adc_code_i);
                    next_avg_cnt = avg_cnt + 5'h01;
                    next_start   = 1'b1;
                    if (no_avg || (avg_cnt + 5'h01 == mms_pkg::AVG_COUNT)) begin
                        next_rvalid  = 1'b1;
                        next_rch     = ch;
                        next_res     = no_avg ? adc_code_i : 10'((acc + 14'(adc_code_i)) >> 4);
                        next_avg_cnt = 5'h00;
                        next_acc     = 14'h0000;
                        next_ch      = single ? ctrl_two_i[3:0] : step_ch(ch, diode);
                    end
                end
            end
            mms_pkg::ST_HOLD: begin
                if (!enable) begin
                    next_state = mms_pkg::ST_IDLE;
                end else if (!serial_busy_i) begin
                    next_state   = mms_pkg::ST_CONV;
                    next_avg_cnt = 5'h00;
                    next_acc     = 14'h0000;
                    next_start   = 1'b1;
                end
            end
            default: begin
                next_state = mms_pkg::ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // protocol lock: set only, cleared by reset
    always_comb begin
        next_spi_lock = spi_lock | spi_select_i;
    end

    // sequencer and lock registers
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            state    <= mms_pkg::ST_CAL;
            cal_cnt  <= 23'h00_0000;
            ch       <= mms_pkg::CH_SUPPLY;
            avg_cnt  <= 5'h00;
            acc      <= 14'h0000;
            start    <= 1'b0;
            rvalid   <= 1'b0;
            res      <= 10'h000;
            rch      <= mms_pkg::CH_SUPPLY;
            spi_lock <= 1'b0;
        end else begin
            state    <= next_state;
            cal_cnt  <= next_cal_cnt;
            ch       <= next_ch;
            avg_cnt  <= next_avg_cnt;
            acc      <= next_acc;
            start    <= next_start;
            rvalid   <= next_rvalid;
            res      <= next_res;  // held while idle
            rch      <= next_rch;
            spi_lock <= next_spi_lock;
        end
    end

    // ==========================================
    // outputs
    assign cal_done_o        = (state != mms_pkg::ST_CAL);
    assign monitoring_o      = (state == mms_pkg::ST_CONV) || (state == mms_pkg::ST_HOLD);
    assign channel_o         = ch;
    assign conv_start_o      = start;
    assign adc_reset_o       = serial_busy_i;
    assign fast_clk_o        = fast;
    assign diode_filter_on_o = !fast;
    assign ref_supply_o      = ctrl_three_i[mms_pkg::FIELD_BIT_FOUR];
    assign diode_mode_o      = diode;
    assign spi_locked_o      = spi_lock;
    assign result_valid_o    = rvalid;
    assign result_ch_o       = rch;
    assign result_o          = res;
    // configuration controls passed to their consumers
    assign int_enable_o      = ctrl_three_i[mms_pkg::FIELD_INT_ENABLE];
    assign int_active_high_o = ctrl_three_i[mms_pkg::FIELD_INT_POLARITY];
    assign timeout_enable_o  = ctrl_three_i[mms_pkg::FIELD_TIMEOUT_EN];
    assign soft_reset_o      = ctrl_three_i[mms_pkg::FIELD_SOFT_RESET];
endmodule // mms_sequencer

//--- sim/mms_adc_model.sv
// converter model: channel-tagged code, dithered per conversion
`timescale 1ns/10ps
module mms_adc_model (
    input  wire logic       mclk_i,
    input  wire logic       conv_start_i,
    input  wire logic       adc_reset_i,
    input  wire logic [3:0] channel_i,
    input  wire logic [4:0] salt_i,
    input  wire logic       dither_i,
    output logic      [9:0] adc_code_o
);
    logic       up = 1'b0;
    logic [9:0] base;
    // ===========
    // dither phase flips per start, cleared by converter reset
    always_ff @(posedge mclk_i) begin
        if (adc_reset_i) begin
            up <= 1'b0;
        end else if (conv_start_i) begin
            up <= !up;
        end
    end
    // code pair averages back to base; garbage while in reset
    assign base = {1'b1, salt_i, channel_i};
    assign adc_code_o = adc_reset_i ? ~base : base + (!dither_i ? 10'h000 : up ? 10'h001 : 10'h3ff);
endmodule // mms_adc_model

//--- sim/mms_sequencer_assertions.sv
// port-level assertions for the measurement sequencer
`timescale 1ns/10ps
module mms_sequencer_checker (
    input wire logic       mclk_i,
    input wire logic       nrst_i,
    input wire logic [7:0] ctrl_one_i,
    input wire logic [7:0] ctrl_three_i,
    input wire logic       spi_select_i,
    input wire logic       serial_busy_i,
    input wire logic       cal_done_o,
    input wire logic       monitoring_o,
    input wire logic [3:0] channel_o,
    input wire logic       conv_start_o,
    input wire logic       adc_reset_o,
    input wire logic       fast_clk_o,
    input wire logic       diode_filter_on_o,
    input wire logic       ref_supply_o,
    input wire logic       diode_mode_o,
    input wire logic       spi_locked_o,
    input wire logic       result_valid_o,
    input wire logic [3:0] result_ch_o,
    input wire logic [9:0] result_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ===========
    // sequencing
    AST_CAL_QUIET: assert property (!cal_done_o |-> !conv_start_o && !monitoring_o)
        else $error("activity before calibration end");
    AST_IDLE_STOP: assert property (!ctrl_one_i[0] [*3] |-> !conv_start_o)
        else $error("start while disabled");
    AST_HOLD_RES: assert property (!result_valid_o |-> $stable(result_o))
        else $error("result moved without valid");
    AST_RES_CH: assert property (result_valid_o |-> result_ch_o == $past(channel_o))
        else $error("result channel differs from measured");
    AST_ABORT: assert property (adc_reset_o == serial_busy_i)
        else $error("converter reset not following transaction");
    AST_NO_START: assert property (serial_busy_i |=> !conv_start_o)
        else $error("start during transaction");
    AST_RESTART: assert property ($fell(serial_busy_i) && ctrl_one_i[0] && cal_done_o |-> ##[1:2] conv_start_o)
        else $error("no restart after transaction");
    // ===========
    // static selections
    AST_SPI: assert property (spi_select_i || spi_locked_o |=> spi_locked_o)
        else $error("protocol lock lost");
    AST_FILTER: assert property (fast_clk_o == ctrl_three_i[0] && diode_filter_on_o != fast_clk_o)
        else $error("clock or filter select wrong");
    AST_REF: assert property (ref_supply_o == ctrl_three_i[4])
        else $error("reference select wrong");
    AST_DIODE: assert property (diode_mode_o == (ctrl_one_i[1] | ctrl_one_i[2]))
        else $error("diode mode wrong");
    // main scenarios reached
    COV_DIODE: cover property (result_valid_o && diode_mode_o);
    COV_ABORT: cover property ($fell(serial_busy_i) && ctrl_one_i[0]);
    COV_LOCK: cover property (spi_locked_o);
endmodule // mms_sequencer_checker
bind mms_sequencer mms_sequencer_checker i_mms_sequencer_checker (.mclk_i, .nrst_i, .ctrl_one_i,
    .ctrl_three_i, .spi_select_i, .serial_busy_i, .cal_done_o, .monitoring_o, .channel_o, .conv_start_o,
    .adc_reset_o, .fast_clk_o, .diode_filter_on_o, .ref_supply_o, .diode_mode_o, .spi_locked_o,
    .result_valid_o, .result_ch_o, .result_o);

//--- sim/test_mms_sequencer.sv
// self-checking bench for the measurement sequencer
`timescale 1ns/10ps
module test_mms_sequencer;
    logic       mclk_i = 1'b0, nrst_i = 1'b0, spi_select_i = 1'b0, serial_busy_i = 1'b0, dith = 1'b1;
    logic [7:0] ctrl_one_i = 8'h00, ctrl_two_i = 8'h00, ctrl_three_i = 8'h00;
    logic [4:0] salt = 5'h00;
    logic [9:0] adc_code_i, result_o;
    logic [3:0] channel_o, result_ch_o;
    logic       cal_done_o, monitoring_o, conv_start_o, adc_reset_o, fast_clk_o, diode_filter_on_o;
    logic       ref_supply_o, diode_mode_o, spi_locked_o, result_valid_o;
    logic       int_enable_o, int_active_high_o, timeout_enable_o, soft_reset_o;
    int         n_fail = 0, comparisons = 0, exp_ch = 0, cyc = 0, gap_on = 0;
    logic [7:0] modes [3] = '{8'h01, 8'h03, 8'h05};
    logic [9:0] exp_q [$];
    localparam int SLOW_T = 4;
    localparam int FAST_T = 2;
    // ===========
    // design, converter model, clock
    mms_sequencer #(.CAL_CYCLES(10), .SLOW_TICKS(SLOW_T), .FAST_TICKS(FAST_T)) i_mms_sequencer (.mclk_i, .nrst_i,
        .ctrl_one_i, .ctrl_two_i, .ctrl_three_i, .spi_select_i, .serial_busy_i, .adc_code_i, .cal_done_o,
        .monitoring_o, .channel_o, .conv_start_o, .adc_reset_o, .fast_clk_o, .diode_filter_on_o,
        .ref_supply_o, .diode_mode_o, .spi_locked_o, .result_valid_o, .result_ch_o, .result_o,
        .int_enable_o, .int_active_high_o, .timeout_enable_o, .soft_reset_o);
    mms_adc_model i_mms_adc_model (.mclk_i, .conv_start_i(conv_start_o), .adc_reset_i(adc_reset_o),
        .channel_i(channel_o), .salt_i(salt), .dither_i(dith), .adc_code_o(adc_code_i));
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    // ===========
    // helpers
    task automatic chk(input logic [9:0] seen, input logic [9:0] want);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // reference order of channels
    function automatic int nxt(int c);
        if (ctrl_two_i[4]) return int'(ctrl_two_i[3:0]);
        if (c == 1) return (ctrl_one_i[1] | ctrl_one_i[2]) ? 2 : 3;
        if (c == 2) return 5;
        return (c == 10) ? 0 : c + 1;
    endfunction
    task automatic wait_res(input bit chk_it);
        cyc = 0;
        do begin
            @(posedge mclk_i);
            #1;
            cyc++;
        end while (result_valid_o !== 1'b1 && cyc < 3000);
        if (cyc >= 3000) begin
            n_fail++;
            $display("mismatch at %0t: no result", $time);
            conclude();
        end
        if (chk_it) begin
            exp_q.push_back({1'b1, salt, exp_ch[3:0]});
            chk(monitoring_o, 1'b1);
            chk(result_ch_o, exp_ch);
            chk(result_o, exp_q.pop_front());
        end
        exp_ch = nxt(exp_ch);
    endtask
    task automatic run(input logic [7:0] one, input int n);
        @(negedge mclk_i);
        ctrl_one_i = one;
        exp_ch = 0; // supply measured first
        repeat (n) wait_res(1'b1);
    endtask
    task automatic stop();
        logic [9:0] held;
        @(negedge mclk_i);
        ctrl_one_i = 8'h00;
        repeat (2) @(negedge mclk_i);
        held = result_o;
        repeat (40) begin
            @(negedge mclk_i);
            chk({monitoring_o, conv_start_o}, 0);
        end
        chk(result_o, held);
    endtask
    // ===========
    // main sequence
    initial begin
        void'($urandom(32'h0c60));
        repeat (8) @(negedge mclk_i);
        nrst_i = 1'b1; // host quiet through calibration
        chk(cal_done_o, 1'b0);
        repeat (40) begin
            chk({monitoring_o, conv_start_o}, 0);
            @(negedge mclk_i);
        end
        chk({cal_done_o, spi_locked_o}, 2);
        $display("test idle done");
        foreach (modes[i]) begin
            salt = 5'($urandom);
            run(modes[i], 11);
            gap_on = cyc;
            chk(gap_on, 16 * (SLOW_T + 2));
            stop();
            $display("test mode %h done", modes[i]);
        end
        run(8'h01, 2);
        repeat (5) @(negedge mclk_i);
        serial_busy_i = 1'b1;
        @(negedge mclk_i);
        chk(adc_reset_o, 1);
        repeat (4) @(negedge mclk_i);
        serial_busy_i = 1'b0;
        repeat (3) wait_res(1'b1);
        stop();
        $display("test abort done");
        run(8'h01, 1);
        @(negedge mclk_i);
        ctrl_two_i = 8'h10 | 8'($urandom_range(10));
        wait_res(1'b0);
        repeat (3) wait_res(1'b1);
        stop();
        $display("test single done");
        ctrl_two_i = 8'h20;
        ctrl_three_i = 8'h01;
        dith = 1'b0;
        run(8'h01, 11);
        chk(cyc * 8 < gap_on, 1);
        chk(cyc, FAST_T + 2);
        stop();
        $display("test fast done");
        repeat (16) begin
            @(negedge mclk_i);
            ctrl_three_i = 8'($urandom);
            ctrl_one_i = 8'($urandom) & 8'hfe;
            #1;
            chk({fast_clk_o, diode_filter_on_o, ref_supply_o, diode_mode_o},
                {ctrl_three_i[0], !ctrl_three_i[0], ctrl_three_i[4], ctrl_one_i[1] | ctrl_one_i[2]});
            chk({int_enable_o, int_active_high_o, timeout_enable_o, soft_reset_o},
                {ctrl_three_i[1], ctrl_three_i[2], ctrl_three_i[6], ctrl_three_i[7]});
        end
        $display("test decode done");
        @(negedge mclk_i);
        spi_select_i = 1'b1;
        @(negedge mclk_i);
        spi_select_i = 1'b0;
        repeat (5) @(negedge mclk_i);
        chk(spi_locked_o, 1);
        nrst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        nrst_i = 1'b1;
        chk(spi_locked_o, 0);
        $display("test protocol done");
        conclude();
    end
endmodule // test_mms_sequencer
